//--- core/pgr_vendor_pages.sv
// builds and streams the three vendor inquiry pages byte by byte
// assumes the command source and the data-in consumer run on clk
// How it works
// - byte 0 of every page is zero: lun supported, direct-access device
// - byte 1 echoes the requested page code
// - mechanical page: byte 2 zero, byte 3 page length 50h
// - mechanical page carries five 16-byte text fields, bytes 4 to 83
// - card page: byte 2 zero, byte 3 page length 34h
// - card page: three text fields each after a length byte 10h; byte 55 zero
// - flash page: two-byte page length 001ch in bytes 2-3
// - flash page bytes 4-7 reserved flags; byte 4 bit 0 shows cache enable
// - flash page bytes 8-15 reserved; 16-31 hold flash firmware version text
// - with media unavailable, every byte after the header reads as space
// - text is alphanumeric, left aligned, padded with spaces
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module pgr_vendor_pages
	import pgr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic [7:0]      reg_rdata,
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_page,
	output logic            cmd_ready,
	output logic            cmd_reject,
	output logic            page_valid,
	output logic [7:0]      page_data,
	output logic            page_last,
	input  wire logic       page_ready
);
	pgr_mem_if     mem ();
	pgr_state_type state;
	logic [7:0]    ctrl;
	logic          bad_page;
	logic [7:0]    page;
	logic [7:0]    idx;
	logic          pad;
	pgr_slot_type  slot;
	logic [7:0]    next_byte;
	logic          keep;
	logic          push;
	logic          accept;
	logic          supported;
	logic          load_ready;
	logic          text_hit;
	logic          media;
	logic          flash_backed_cache_enabled;

	assign media                      = ctrl[PGR_CTRL_MEDIA];
	assign flash_backed_cache_enabled = ctrl[PGR_CTRL_CACHE];

	// where byte i of page pg comes from: a fixed value or a text store address
	function automatic pgr_slot_type slot_of(input logic [7:0] pg, input logic [7:0] i, input logic cache_on);
		pgr_slot_type s;
		s = '0;
		s.fixed = PGR_ZERO;
		if (i == PGR_IDX_TYPE)
			s.fixed = PGR_HDR_DEVICE;
		else if (i == PGR_IDX_CODE)
			s.fixed = pg;
		else if (i == PGR_IDX_LEN_HI)
			s.fixed = PGR_ZERO;
		else if (i == PGR_IDX_LEN_LO)
			s.fixed = (pg == PGR_PAGE_MECH) ? PGR_LEN_MECH :
				(pg == PGR_PAGE_CARD) ? PGR_LEN_CARD : PGR_LEN_FLASH;
		else if (pg == PGR_PAGE_MECH)
		begin
			s.text = 1'b1;
			s.addr = i - PGR_IDX_BODY + PGR_TXT_MECH;
		end
		else if (pg == PGR_PAGE_CARD)
		begin
			if (i == PGR_CARD_VERL || i == PGR_CARD_SERL || i == PGR_CARD_PNL)
				s.fixed = PGR_FIELD_LEN;
			else if (i == PGR_CARD_LAST)
				s.fixed = PGR_ZERO;
			else if (i >= PGR_CARD_PN)
			begin
				s.text = 1'b1;
				s.addr = i - PGR_CARD_PN + PGR_TXT_PN;
			end
			else if (i >= PGR_CARD_SER)
			begin
				s.text = 1'b1;
				s.addr = i - PGR_CARD_SER + PGR_TXT_SER;
			end
			else
			begin
				s.text = 1'b1;
				s.addr = i - PGR_CARD_VER + PGR_TXT_VER;
			end
		end
		else
		begin
			if (i == PGR_FLASH_FLAGS)
				s.fixed[PGR_CACHE_BIT] = cache_on;
			else if (i >= PGR_FLASH_FW)
			begin
				s.text = 1'b1;
				s.addr = i - PGR_FLASH_FW + PGR_TXT_FW;
			end
		end
		s.first = s.text && ((s.addr & PGR_FIELD_MASK) == PGR_ZERO);
		s.last = i == ((pg == PGR_PAGE_MECH) ? PGR_MECH_LAST :
			(pg == PGR_PAGE_CARD) ? PGR_CARD_LAST : PGR_FLASH_LAST);
		return s;
	endfunction : slot_of

	// decode of the current byte and command acceptance
	assign slot      = slot_of(page, idx, flash_backed_cache_enabled);
	assign supported = cmd_page == PGR_PAGE_MECH || cmd_page == PGR_PAGE_CARD || cmd_page == PGR_PAGE_FLASH;
	assign cmd_ready = state == ST_IDLE;
	assign accept    = ce && cmd_valid && cmd_ready;
	assign push      = ce && state == ST_EMIT && load_ready;

	// a text byte survives only if alphanumeric and no pad seen earlier in the field
	assign keep = pgr_is_alnum(mem.rd_data) && (slot.first || !pad);

	// byte composition; media loss blanks everything past the header
	always_comb
	begin
		if (!media && idx >= PGR_IDX_BODY)
			next_byte = PGR_SPACE;
		else if (slot.text)
			next_byte = keep ? mem.rd_data : PGR_SPACE;
		else
			next_byte = slot.fixed;
	end

	// text store ports: read in fetch, write from the register port
	assign text_hit    = reg_addr >= PGR_REG_TEXT && reg_addr < PGR_REG_TEXT_END;
	assign mem.rd_en   = ce && state == ST_FETCH && slot.text;
	assign mem.rd_addr = slot.addr;
	assign mem.wr_en   = reg_write && text_hit;
	assign mem.wr_addr = reg_addr - PGR_REG_TEXT;
	assign mem.wr_data = reg_wdata;

	pgr_text_mem u_mem (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.mem (mem)
	);

	pgr_out_stage u_out (
		.clk        (clk),
		.rst        (rst),
		.ce         (ce),
		.load       (push),
		.load_data  (next_byte),
		.load_last  (slot.last),
		.load_ready (load_ready),
		.out_valid  (page_valid),
		.out_data   (page_data),
		.out_last   (page_last),
		.out_ready  (page_ready)
	);

	// sequencer: one byte per two cycles keeps the ram read latency simple
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			page  <= PGR_ZERO;
			idx   <= PGR_IDX_TYPE;
		end
		else if (ce)
		begin
			case (state)
				ST_IDLE:
				begin
					if (accept && supported)
					begin
						page  <= cmd_page;
						idx   <= PGR_IDX_TYPE;
						state <= ST_FETCH;
					end
				end
				ST_FETCH:
					state <= ST_EMIT;
				ST_EMIT:
				begin
					if (load_ready)
					begin
						idx   <= idx + PGR_IDX_STEP;
						state <= slot.last ? ST_IDLE : ST_FETCH;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// pad tracking: once a field turns to padding it stays padded
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pad <= 1'b0;
		else if (push && slot.text)
			pad <= !keep;
	end

	// control register and sticky unsupported-page flag; set beats clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl <= PGR_CTRL_RESET;
		else if (ce && reg_write && reg_addr == PGR_REG_CTRL)
			ctrl <= reg_wdata;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			bad_page <= 1'b0;
		else if (accept && !supported)
			bad_page <= 1'b1;
		else if (ce && reg_write && reg_addr == PGR_REG_STATUS && reg_wdata[PGR_STAT_BAD])
			bad_page <= 1'b0;
	end

	// reject pulse, one cycle after the refused command
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cmd_reject <= 1'b0;
		else if (ce)
			cmd_reject <= accept && !supported;
	end

	// register read data valid only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= PGR_ZERO;
		else if (ce)
		begin
			reg_rdata <= PGR_ZERO;
			if (reg_read && reg_addr == PGR_REG_CTRL)
				reg_rdata <= ctrl;
			else if (reg_read && reg_addr == PGR_REG_STATUS)
			begin
				reg_rdata[PGR_STAT_BUSY] <= state != ST_IDLE;
				reg_rdata[PGR_STAT_BAD]  <= bad_page;
			end
		end
	end

	chk_header_type: assert property (@(posedge clk) disable iff (rst)
		push && idx == PGR_IDX_TYPE |-> next_byte == PGR_HDR_DEVICE) else $error("byte 0 not zero");
	chk_code_echo: assert property (@(posedge clk) disable iff (rst)
		push && idx == PGR_IDX_CODE |-> next_byte == page) else $error("page code not echoed");
	chk_mech_length: assert property (@(posedge clk) disable iff (rst)
		push && page == PGR_PAGE_MECH && idx == PGR_IDX_LEN_LO |-> next_byte == PGR_LEN_MECH) else $error("mech length wrong");
	chk_mech_text_addr: assert property (@(posedge clk) disable iff (rst)
		ce && state == ST_FETCH && page == PGR_PAGE_MECH && idx >= PGR_IDX_BODY
		|-> mem.rd_en && mem.rd_addr == idx - PGR_IDX_BODY) else $error("mech text address wrong");
	chk_card_length: assert property (@(posedge clk) disable iff (rst)
		push && page == PGR_PAGE_CARD && idx == PGR_IDX_LEN_LO |-> next_byte == PGR_LEN_CARD) else $error("card length wrong");
	chk_card_field_len: assert property (@(posedge clk) disable iff (rst)
		push && media && page == PGR_PAGE_CARD
		&& (idx == PGR_CARD_VERL || idx == PGR_CARD_SERL || idx == PGR_CARD_PNL)
		|-> next_byte == PGR_FIELD_LEN) else $error("card field length byte wrong");
	chk_card_tail: assert property (@(posedge clk) disable iff (rst)
		push && page == PGR_PAGE_CARD && idx == PGR_CARD_LAST |-> slot.last && next_byte == (media ? PGR_ZERO : PGR_SPACE))
		else $error("card tail byte wrong");
	chk_flash_length: assert property (@(posedge clk) disable iff (rst)
		push && page == PGR_PAGE_FLASH && (idx == PGR_IDX_LEN_HI || idx == PGR_IDX_LEN_LO)
		|-> next_byte == ((idx == PGR_IDX_LEN_HI) ? PGR_ZERO : PGR_LEN_FLASH)) else $error("flash length wrong");
	chk_cache_flag: assert property (@(posedge clk) disable iff (rst)
		push && media && page == PGR_PAGE_FLASH && idx == PGR_FLASH_FLAGS
		|-> next_byte[PGR_CACHE_BIT] == flash_backed_cache_enabled && next_byte[7:1] == PGR_ZERO[7:1])
		else $error("cache flag byte wrong");
	chk_flash_reserved: assert property (@(posedge clk) disable iff (rst)
		push && media && page == PGR_PAGE_FLASH && idx > PGR_FLASH_FLAGS && idx < PGR_FLASH_FW
		|-> next_byte == PGR_ZERO) else $error("flash reserved byte not zero");
	chk_media_blank: assert property (@(posedge clk) disable iff (rst)
		push && !media && idx >= PGR_IDX_BODY |-> next_byte == PGR_SPACE) else $error("blank byte not space");
	chk_text_class: assert property (@(posedge clk) disable iff (rst)
		push && slot.text |-> next_byte == PGR_SPACE || pgr_is_alnum(next_byte)) else $error("text byte not alphanumeric");
	chk_byte_order: assert property (@(posedge clk) disable iff (rst)
		push |=> idx == $past(idx) + PGR_IDX_STEP && state == ($past(slot.last) ? ST_IDLE : ST_FETCH))
		else $error("byte order broken");
	chk_start_index: assert property (@(posedge clk) disable iff (rst)
		accept && supported |=> state == ST_FETCH && idx == PGR_IDX_TYPE && page == $past(cmd_page))
		else $error("page not started at byte 0");
endmodule : pgr_vendor_pages
`default_nettype wire

//--- core/pgr_pkg.sv
// constants, types and helpers shared by the vendor page responder
// assumes one 250 MHz clock domain and a same-clock data-in consumer
package pgr_pkg;
	// page codes served and their header contents
	localparam logic [7:0] PGR_PAGE_MECH   = 8'hd1;
	localparam logic [7:0] PGR_PAGE_CARD   = 8'hd2;
	localparam logic [7:0] PGR_PAGE_FLASH  = 8'hd9;
	localparam logic [7:0] PGR_HDR_DEVICE  = 8'h00;
	localparam logic [7:0] PGR_ZERO        = 8'h00;
	localparam logic [7:0] PGR_SPACE       = 8'h20;
	localparam logic [7:0] PGR_LEN_MECH    = 8'h50;
	localparam logic [7:0] PGR_LEN_CARD    = 8'h34;
	localparam logic [7:0] PGR_LEN_FLASH   = 8'h1c;
	localparam logic [7:0] PGR_FIELD_LEN   = 8'h10;
	localparam logic [7:0] PGR_FIELD_MASK  = 8'h0f;
	localparam int         PGR_CACHE_BIT   = 0;
	// byte indexes within a page
	localparam logic [7:0] PGR_IDX_TYPE    = 8'h00;
	localparam logic [7:0] PGR_IDX_CODE    = 8'h01;
	localparam logic [7:0] PGR_IDX_LEN_HI  = 8'h02;
	localparam logic [7:0] PGR_IDX_LEN_LO  = 8'h03;
	localparam logic [7:0] PGR_IDX_BODY    = 8'h04;
	localparam logic [7:0] PGR_IDX_STEP    = 8'h01;
	localparam logic [7:0] PGR_MECH_LAST   = 8'h53;
	localparam logic [7:0] PGR_CARD_VERL   = 8'h04;
	localparam logic [7:0] PGR_CARD_VER    = 8'h05;
	localparam logic [7:0] PGR_CARD_SERL   = 8'h15;
	localparam logic [7:0] PGR_CARD_SER    = 8'h16;
	localparam logic [7:0] PGR_CARD_PNL    = 8'h26;
	localparam logic [7:0] PGR_CARD_PN     = 8'h27;
	localparam logic [7:0] PGR_CARD_LAST   = 8'h37;
	localparam logic [7:0] PGR_FLASH_FLAGS = 8'h04;
	localparam logic [7:0] PGR_FLASH_FW    = 8'h10;
	localparam logic [7:0] PGR_FLASH_LAST  = 8'h1f;
	// text store layout: nine 16-byte fields
	localparam logic [7:0] PGR_TXT_MECH    = 8'h00;
	localparam logic [7:0] PGR_TXT_VER     = 8'h50;
	localparam logic [7:0] PGR_TXT_SER     = 8'h60;
	localparam logic [7:0] PGR_TXT_PN      = 8'h70;
	localparam logic [7:0] PGR_TXT_FW      = 8'h80;
	localparam int         PGR_TEXT_DEPTH  = 144;
	// software register map
	localparam logic [7:0] PGR_REG_CTRL    = 8'h00;
	localparam logic [7:0] PGR_REG_STATUS  = 8'h01;
	localparam logic [7:0] PGR_REG_TEXT    = 8'h40;
	localparam logic [7:0] PGR_REG_TEXT_END = 8'hd0;
	localparam logic [7:0] PGR_CTRL_RESET  = 8'h00;
	localparam int         PGR_CTRL_MEDIA  = 0;
	localparam int         PGR_CTRL_CACHE  = 1;
	localparam int         PGR_STAT_BUSY   = 0;
	localparam int         PGR_STAT_BAD    = 1;
	// character class bounds
	localparam logic [7:0] PGR_CH_0 = 8'h30;
	localparam logic [7:0] PGR_CH_9 = 8'h39;
	localparam logic [7:0] PGR_CH_UA = 8'h41;
	localparam logic [7:0] PGR_CH_UZ = 8'h5a;
	localparam logic [7:0] PGR_CH_LA = 8'h61;
	localparam logic [7:0] PGR_CH_LZ = 8'h7a;

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EMIT} pgr_state_type;

	typedef struct packed {
		logic       text;
		logic       first;
		logic       last;
		logic [7:0] addr;
		logic [7:0] fixed;
	} pgr_slot_type;

	// true for 0-9, A-Z, a-z
	function automatic logic pgr_is_alnum(input logic [7:0] b);
		return (b >= PGR_CH_0 && b <= PGR_CH_9) || (b >= PGR_CH_UA && b <= PGR_CH_UZ)
			|| (b >= PGR_CH_LA && b <= PGR_CH_LZ);
	endfunction : pgr_is_alnum
endpackage : pgr_pkg

//--- core/pgr_mem_if.sv
// write and read ports of the text store
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface pgr_mem_if;
	logic       wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic       rd_en;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	modport owner (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
	modport store (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : pgr_mem_if
`default_nettype wire

//--- core/pgr_text_mem.sv
// text store for the identification fields, registered read data
// assumes software loads every byte before the first page is served
`timescale 1ns/1ns
`default_nettype none
module pgr_text_mem
	import pgr_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	pgr_mem_if.store  mem
);
	logic [7:0] cells [PGR_TEXT_DEPTH];

	// array itself has no reset so it can map onto ram
	always_ff @(posedge clk)
	begin
		if (ce && mem.wr_en)
		begin
			cells[mem.wr_addr] <= mem.wr_data;
		end
	end

	// one cycle read latency
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			mem.rd_data <= PGR_ZERO;
		else if (ce && mem.rd_en)
			mem.rd_data <= cells[mem.rd_addr];
	end
endmodule : pgr_text_mem
`default_nettype wire

//--- core/pgr_out_stage.sv
// single output register with valid and ready toward the data-in consumer
// assumes the consumer shares clk; a transfer needs ce high as well
`timescale 1ns/1ns
`default_nettype none
module pgr_out_stage
	import pgr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       load,
	input  wire logic [7:0] load_data,
	input  wire logic       load_last,
	output logic            load_ready,
	output logic            out_valid,
	output logic [7:0]      out_data,
	output logic            out_last,
	input  wire logic       out_ready
);
	// full throughput: refills in the cycle the old byte leaves
	assign load_ready = !out_valid || out_ready;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_valid <= 1'b0;
			out_data  <= PGR_ZERO;
			out_last  <= 1'b0;
		end
		else if (ce)
		begin
			if (load && load_ready)
			begin
				out_valid <= 1'b1;
				out_data  <= load_data;
				out_last  <= load_last;
			end
			else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule : pgr_out_stage
`default_nettype wire

//--- test/pgr_initiator_model.sv
// behavioural initiator: one inquiry command per start pulse, then sinks the page bytes
// assumes it shares clk with the responder; start is a one-cycle pulse from the bench
`timescale 1ns/1ns
`default_nettype none
module pgr_initiator_model
	import pgr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       start,
	input  wire logic [7:0] start_page,
	input  wire logic       slow,
	input  wire logic       cmd_ready,
	output logic            cmd_valid,
	output logic [7:0]      cmd_page,
	output logic            page_ready
);
	// request held until the taken edge; the code is inverted once released so a stale value never matches
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cmd_valid <= 1'b0;
			cmd_page  <= 8'h00;
		end
		else if (start)
		begin
			cmd_valid <= 1'b1;
			cmd_page  <= start_page;
		end
		else if (cmd_valid && cmd_ready && ce)
		begin
			cmd_valid <= 1'b0;
			cmd_page  <= ~cmd_page;
		end
	end

	// a slow initiator stalls the data-in phase at random
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			page_ready <= 1'b0;
		else
			page_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
	end
endmodule : pgr_initiator_model
`default_nettype wire

//--- test/pgr_vendor_pages_tb.sv
// self-checking bench for the vendor page responder
// assumes the initiator model in its own file; expected bytes are queued and compared by a monitor
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
	$display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module pgr_vendor_pages_tb
	import pgr_pkg::*;
;
	logic       clk, rst, ce, reg_write, reg_read, start, slow, rd_d;
	logic       cmd_valid, cmd_ready, cmd_reject, page_valid, page_last, page_ready, media, cache;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, start_page, cmd_page, page_data, take_page, e8;
	logic [8:0] e9;
	logic [7:0] clean [PGR_TEXT_DEPTH];
	logic [7:0] reg_q [$];
	logic [7:0] rej_q [$];
	logic [8:0] page_q [$];
	logic [7:0] codes [4] = '{PGR_PAGE_MECH, 8'hd3, PGR_PAGE_CARD, PGR_PAGE_FLASH};
	int         n_errors, comparisons;

	pgr_vendor_pages dut_u (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
		.cmd_page(cmd_page), .cmd_ready(cmd_ready), .cmd_reject(cmd_reject), .page_valid(page_valid),
		.page_data(page_data), .page_last(page_last), .page_ready(page_ready));

	pgr_initiator_model host_u (.clk(clk), .rst(rst), .ce(ce), .start(start), .start_page(start_page),
		.slow(slow), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_page(cmd_page), .page_ready(page_ready));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// expected page byte, worked out from the page layouts and the cleaned text
	function automatic logic [7:0] exp_byte(input logic [7:0] pg, input int i);
		if (i == 0 || i == 2)
			return 8'h00;
		if (i == 1)
			return pg;
		if (i == 3)
			return (pg == PGR_PAGE_MECH) ? 8'h50 : (pg == PGR_PAGE_CARD) ? 8'h34 : 8'h1c;
		if (!media)
			return 8'h20;
		if (pg == PGR_PAGE_MECH)
			return clean[i - 4];
		if (pg == PGR_PAGE_CARD)
		begin
			if (i == 4 || i == 21 || i == 38)
				return 8'h10;
			if (i == 55)
				return 8'h00;
			return clean[80 + (i - 5) / 17 * 16 + (i - 5) % 17];
		end
		if (i == 4)
			return {7'h00, cache};
		if (i < 16)
			return 8'h00;
		return clean[128 + i - 16];
	endfunction : exp_byte

	function automatic logic [7:0] alnum();
		int r;
		r = $urandom_range(61, 0);
		return (r < 10) ? 8'(48 + r) : (r < 36) ? 8'(55 + r) : 8'(61 + r);
	endfunction : alnum

	// one gap cycle after each strobe so no strobe is assigned twice in a time step
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		@(posedge clk);
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		reg_q.push_back(exp);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(posedge clk);
	endtask : reg_rd

	// each field: up to 16 alphanumerics, a dash that ends a shorter text, then junk that must read as blanks
	task automatic load_text();
		int len;
		for (int f = 0; f < 9; f++)
		begin
			len = (f == 0) ? 16 : (f == 1) ? 0 : $urandom_range(16, 0);
			for (int j = 0; j < 16; j++)
			begin
				clean[f * 16 + j] = (j < len) ? alnum() : 8'h20;
				reg_wr(8'(64 + f * 16 + j), (j == len) ? 8'h2d : (j < len) ? clean[f * 16 + j] : alnum());
			end
		end
	endtask : load_text

	task automatic run_page(input logic [7:0] pg, input logic sl);
		int n;
		n = (pg == PGR_PAGE_MECH) ? 84 : (pg == PGR_PAGE_CARD) ? 56 : (pg == PGR_PAGE_FLASH) ? 32 : 0;
		for (int i = 0; i < n; i++)
			page_q.push_back({1'(i == n - 1), exp_byte(pg, i)});
		if (n == 0)
			rej_q.push_back(pg);
		slow       <= sl;
		start_page <= pg;
		start      <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		// a stalling run also drops the clock enable at random to prove the freeze
		for (int k = 0; k < 3000 && (page_q.size() > 0 || rej_q.size() > 0); k++)
		begin
			ce <= !sl || 1'($urandom_range(3, 0) != 0);
			@(posedge clk);
		end
		ce <= 1'b1;
		`CHK(page_q.size() + rej_q.size(), 0)
	endtask : run_page

	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	// monitor: takes the oldest note whenever a result shows at the outputs
	always @(posedge clk)
	begin
		if (rd_d)
		begin
			e8 = (reg_q.size() > 0) ? reg_q.pop_front() : 8'hxx;
			`CHK(reg_rdata, e8)
		end
		if (page_valid === 1'b1 && page_ready && ce)
		begin
			e9 = (page_q.size() > 0) ? page_q.pop_front() : 9'h1xx;
			`CHK({page_last, page_data}, e9)
		end
		// a frozen reject pulse stands over several edges; count it once, at the enabled one
		if (cmd_reject === 1'b1 && ce)
		begin
			e8 = (rej_q.size() > 0) ? rej_q.pop_front() : 8'hxx;
			`CHK(take_page, e8)
		end
		// the code taken at this edge meets its reject pulse at the next one
		if (cmd_valid && cmd_ready && ce)
			take_page <= cmd_page;
		rd_d <= reg_read && ce && !rst;
	end

	// watchdog sized well above the expected run of some 2k cycles
	initial
	begin
		repeat (60000) @(posedge clk);
		n_errors++;
		end_of_test();
	end

	initial
	begin
		rst         = 1'b1;
		ce          = 1'b1;
		reg_write   = 1'b0;
		reg_read    = 1'b0;
		reg_addr    = 8'h00;
		reg_wdata   = 8'h00;
		start       = 1'b0;
		start_page  = 8'h00;
		slow        = 1'b0;
		media       = 1'b0;
		cache       = 1'b0;
		n_errors    = 0;
		comparisons = 0;
		void'($urandom(49));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		reg_rd(PGR_REG_CTRL, 8'h00);
		reg_rd(PGR_REG_STATUS, 8'h00);
		reg_rd(8'h02, 8'h00);
		load_text();
		reg_rd(PGR_REG_TEXT, 8'h00);
		reg_wr(8'h03, 8'hff);
		reg_wr(PGR_REG_CTRL, 8'ha4);
		reg_rd(PGR_REG_CTRL, 8'ha4);
		// media off, media on with cache off, then both on with a stalling initiator
		for (int m = 0; m < 3; m++)
		begin
			media = (m > 0);
			cache = (m == 2);
			reg_wr(PGR_REG_CTRL, {6'h00, cache, media});
			foreach (codes[k])
				run_page(codes[k], m == 2);
		end
		run_page(8'h00, 1'b0);
		reg_rd(PGR_REG_STATUS, 8'h02);
		reg_wr(PGR_REG_STATUS, 8'h02);
		reg_rd(PGR_REG_STATUS, 8'h00);
		run_page(PGR_PAGE_FLASH, 1'b0);
		end_of_test();
	end
endmodule : pgr_vendor_pages_tb
`default_nettype wire
